// *** bench/apc_clock_gen_asserts.sv ***
/*
  Port checker for the clock generator.
  Assumes it is bound to apc_clock_gen and sees only its ports.
*/
`timescale 1ns/1ns
module apc_clock_gen_asserts (
  // Clock and reset
  input wire       ref_clk,
  input wire       rst,
  input wire       ce,
  // Register port
  input wire [7:0] reg_addr,
  input wire [7:0] reg_wdata,
  input wire       reg_write,
  input wire       reg_read,
  input wire       reg_rdata_valid,
  // Modes, clocks and events
  input wire       master_mode,
  input wire       hold_clocks,
  input wire       serial_bit_clock_out,
  input wire       serial_bit_clock_oe,
  input wire       frame_sync_clock_out,
  input wire       frame_sync_clock_oe,
  input wire       pll_on_bit,
  input wire [2:0] pll_ref_source,
  input wire       core_clk_tick,
  input wire       sample_tick
);
  reg [7:0] wd_q;
  reg       wr_pll;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Remember last write so field updates can be tied to it
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      wd_q   <= 8'h00;
      wr_pll <= 1'h0;
    end else begin
      wd_q   <= reg_wdata;
      wr_pll <= ce && reg_write && reg_addr == 8'h04;
    end
  end
  rd_valid_a: assert property (ce && reg_read |=> reg_rdata_valid)
    else $error("read not answered");
  stray_valid_a: assert property (ce && !reg_read |=> !reg_rdata_valid)
    else $error("valid without read");
  bit_oe_a: assert property (serial_bit_clock_oe == master_mode)
    else $error("bit clock enable wrong");
  frame_oe_a: assert property (frame_sync_clock_oe == master_mode)
    else $error("frame clock enable wrong");
  slave_quiet_a: assert property (!master_mode [*2] |-> !serial_bit_clock_out && !frame_sync_clock_out)
    else $error("clock driven in slave mode");
  ref_write_a: assert property (ce && reg_write && reg_addr == 8'h0d |=> pll_ref_source == wd_q[6:4])
    else $error("reference field not written");
  pll_write_a: assert property (ce && reg_write && reg_addr == 8'h04 |=> pll_on_bit == wd_q[0])
    else $error("enable bit not written");
  pll_hold_a: assert property (!$stable(pll_on_bit) |-> wr_pll)
    else $error("enable bit changed alone");
  held_quiet_a: assert property (hold_clocks [*2] |-> !core_clk_tick && !sample_tick)
    else $error("tick while clocks held");
endmodule // apc_clock_gen_asserts

bind apc_clock_gen apc_clock_gen_asserts u_chk (.ref_clk(ref_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr),
  .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata_valid(reg_rdata_valid),
  .master_mode(master_mode), .hold_clocks(hold_clocks), .serial_bit_clock_out(serial_bit_clock_out),
  .serial_bit_clock_oe(serial_bit_clock_oe), .frame_sync_clock_out(frame_sync_clock_out),
  .frame_sync_clock_oe(frame_sync_clock_oe), .pll_on_bit(pll_on_bit), .pll_ref_source(pll_ref_source),
  .core_clk_tick(core_clk_tick), .sample_tick(sample_tick));

// *** bench/apc_clock_gen_bench.sv ***
/*
  Bench for the clock generator: registers, reference choice, rates and dividers.
  Assumes the host model supplies all reference pins.
*/
`timescale 1ns/1ns
module apc_clock_gen_bench;
  reg       ref_clk = 1'h0, rst = 1'h1, ce = 1'h1, reg_write = 1'h0, reg_read = 1'h0;
  reg       master_mode = 1'h0, hold_clocks = 1'h1, run = 1'h1;
  reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
  wire [7:0] reg_rdata;
  wire [2:0] pll_ref_source;
  wire      valid, mclk, gclk, bclk, bout, boe, fout, foe, pon, ctick, stick;
  integer   num_errors = 0, comparisons = 0;
  // 50 MHz clock
  always #10 ref_clk = ~ref_clk;
  apc_host_model host (.run(run), .system_master_clock(mclk), .gpio_ref_clock(gclk), .serial_bit_clock_in(bclk));
  apc_clock_gen dut (.ref_clk(ref_clk), .rst(rst), .ce(ce), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .reg_rdata_valid(valid),
    .master_mode(master_mode), .hold_clocks(hold_clocks), .system_master_clock(mclk), .gpio_ref_clock(gclk),
    .serial_bit_clock_in(bclk), .serial_bit_clock_out(bout), .serial_bit_clock_oe(boe),
    .frame_sync_clock_out(fout), .frame_sync_clock_oe(foe), .pll_on_bit(pon), .pll_ref_source(pll_ref_source),
    .core_clk_tick(ctick), .sample_tick(stick));
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %0h seen %0h", n, e, g);
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    reg_addr = a;
    reg_wdata = d;
    reg_write = 1'h1;
    @(posedge ref_clk);
    #1 reg_write = 1'h0;
    // One idle edge keeps back-to-back calls from toggling the strobe at once
    @(posedge ref_clk);
    #1;
  endtask
  task rd(input [7:0] a, input [7:0] e);
    reg_addr = a;
    reg_read = 1'h1;
    @(posedge ref_clk);
    #1 reg_read = 1'h0;
    chk("rdata_valid", 1, valid);
    chk("rdata", e, reg_rdata);
    @(posedge ref_clk);
    #1 chk("rdata_valid_end", 0, valid);
  endtask
  function automatic logic pick(input int s);
    case (s)
      0: pick = stick;
      1: pick = bout;
      2: pick = fout;
      default: pick = ctick;
    endcase
  endfunction
  // Cycles up to the next rise of the chosen signal, bounded
  task edge_wait(input int s, output int t);
    logic p;
    p = 1'h1;
    for (t = 0; t < 30000; t++) begin
      @(posedge ref_clk);
      #1;
      if (pick(s) === 1'h1 && p !== 1'h1) break;
      p = pick(s);
    end
  endtask
  task period(input int s, input int e, input string n);
    int t;
    edge_wait(s, t);
    edge_wait(s, t);
    chk(n, e, t + 1);
  endtask
  task t_reset;
    rd(8'h04, 8'h01);
    chk("pll_on_bit", 1, pon);
    rd(8'h0d, 8'h00);
    rd(8'h15, 8'h08);
    rd(8'h21, 8'h00);
  endtask
  task t_regs;
    wr(8'h1b, 8'hff);
    wr(8'h20, 8'hff);
    wr(8'h21, 8'hff);
    wr(8'h30, 8'hff);
    rd(8'h1b, 8'h7f);
    rd(8'h20, 8'h7f);
    rd(8'h21, 8'hff);
    rd(8'h30, 8'h00);
  endtask
  task t_codes;
    int c;
    for (c = 0; c < 8; c++) begin
      wr(8'h0d, {1'h1, c[2:0], 4'hf});
      chk("ref_source", c, pll_ref_source);
    end
    rd(8'h0d, 8'h70);
  endtask
  // Coefficients change only while clocks are held
  task t_rate(input [7:0] on, rs, pc, j, dh, dl, rc, input int e, input string n);
    hold_clocks = 1'h1;
    wr(8'h04, on);
    wr(8'h0d, rs);
    wr(8'h14, pc);
    wr(8'h15, j);
    wr(8'h16, dh);
    wr(8'h17, dl);
    wr(8'h18, rc);
    wr(8'h1b, 8'h0f);
    chk("pll_on_bit", on[0], pon);
    hold_clocks = 1'h0;
    period(0, e, n);
    if (e % 128 == 0) period(3, e / 128, "core_tick");
  endtask
  task t_master(input [7:0] bd, fd, input int bp);
    hold_clocks = 1'h1;
    wr(8'h20, bd);
    wr(8'h21, fd);
    master_mode = 1'h1;
    hold_clocks = 1'h0;
    period(1, bp, "bit_period");
    period(2, bp * (fd + 1), "frame_period");
    chk("bit_oe", 1, boe);
    chk("frame_oe", 1, foe);
    master_mode = 1'h0;
  endtask
  // Main sequence; all rates but pll_off keep the PLL output at 80 to 82 MHz
  initial begin
    repeat (5) @(posedge ref_clk);
    #1 rst = 1'h0;
    t_reset;
    t_regs;
    t_codes;
    t_rate(1, 8'h00, 0, 8, 0, 0, 0, 1280, "pll_int");
    t_rate(1, 8'h00, 0, 8, 8'h07, 8'h80, 0, 1250, "pll_frac");
    t_rate(1, 8'h00, 0, 4, 0, 0, 1, 1280, "pll_post");
    t_rate(1, 8'h00, 1, 16, 0, 0, 0, 1280, "pll_pre");
    t_rate(1, 8'h30, 0, 16, 0, 0, 0, 1280, "gpio_ref");
    t_rate(1, 8'h10, 0, 16, 0, 0, 0, 1280, "bitclk_ref");
    t_rate(0, 8'h30, 0, 16, 0, 0, 0, 10240, "pll_off");
    t_master(0, 3, 10);
    t_master(2, 7, 30);
    end_of_test;
  end
  // Watchdog well past the expected run of about 37000 cycles
  initial begin
    #2000000;
    num_errors++;
    end_of_test;
  end
  task end_of_test;
    if (num_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
endmodule // apc_clock_gen_bench

// *** bench/apc_host_model.sv ***
/*
  Host side clock model: master clock, general-purpose reference and incoming bit clock.
  Assumes the bench raises run while references are wanted; otherwise master and gpio clocks stand at 0 and the bit clock holds.
*/
`timescale 1ns/1ns
module apc_host_model #(
  parameter integer MASTER_HALF = 50,
  parameter integer GPIO_HALF   = 100
) (
  // Control
  input  wire run,
  // Clock pins toward the device
  output reg  system_master_clock,
  output reg  gpio_ref_clock,
  output reg  serial_bit_clock_in
);
  // 10 MHz master, offset so no edge meets the device clock edge
  initial begin
    system_master_clock = 1'h0;
    #3;
    forever #MASTER_HALF system_master_clock = run & ~system_master_clock;
  end
  // 5 MHz reference on the general-purpose pin
  initial begin
    gpio_ref_clock = 1'h0;
    #7;
    forever #GPIO_HALF gpio_ref_clock = run & ~gpio_ref_clock;
  end
  // Bit clock at half the master rate
  initial serial_bit_clock_in = 1'h0;
  always @(posedge system_master_clock) serial_bit_clock_in <= run & ~serial_bit_clock_in;
endmodule // apc_host_model

// *** core/apc_clock_gen.v ***
/*
  Audio PLL clock generator: register file, reference selection, digital
  model of the fractional PLL and the core, bit and frame clock dividers.
  Assumes clock pins arrive asynchronously to ref_clk and are well below
  half its rate; the analog PLL itself is modelled as a rate of ticks.
  Assumes software holds the clocks while it rewrites a coefficient, that
  master_mode and hold_clocks come from logic on ref_clk, and that only
  rate and phase matter to the core, not the shape of each tick.
*/
// Function
// - Drive bit and frame clocks as master
// - Reference chosen by three-bit select field
// - Enable bit clear turns PLL off
// - PLL enable reads set after reset
// - Core 7-bit, bit 7-bit, frame 8-bit dividers
// - Reference accepted from 1 to 50 MHz
// - Output equals reference times R times K over P
// - Coefficient ranges R, P, J and D
// - Multiplier is integer plus four-digit fraction
// - Sample rate is PLL output over 2048
`timescale 1ns/1ns
`include "apc_consts.vh"
module apc_clock_gen (
  // Clock, reset and clock enable
  input  wire       ref_clk,
  input  wire       rst,
  input  wire       ce,
  // Register access from the control port
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_write,
  input  wire       reg_read,
  output reg  [7:0] reg_rdata,
  output reg        reg_rdata_valid,
  // Mode controls
  input  wire       master_mode,
  input  wire       hold_clocks,
  // Clock pins
  input  wire       system_master_clock,
  input  wire       gpio_ref_clock,
  input  wire       serial_bit_clock_in,
  output reg        serial_bit_clock_out,
  output wire       serial_bit_clock_oe,
  output reg        frame_sync_clock_out,
  output wire       frame_sync_clock_oe,
  // Internal clock events and status
  output wire       pll_on_bit,
  output wire [2:0] pll_ref_source,
  output wire       core_clk_tick,
  output wire       sample_tick
);

  // Register file
  reg        pll_on;
  reg  [2:0] ref_sel;
  reg  [3:0] p_code;
  reg  [5:0] j_val;
  reg [13:0] d_raw;
  reg  [3:0] r_code;
  reg  [6:0] core_clk_div;
  reg  [6:0] bitclk_out_div;
  reg  [7:0] frameclk_out_div;

  // Pin synchronisers: index 0 master, 1 bit clock, 2 gpio
  wire [2:0] pin_raw = {gpio_ref_clock, serial_bit_clock_in, system_master_clock};
  reg  [2:0] pin_meta;
  reg  [2:0] pin_sync;
  reg  [2:0] pin_last;
  wire [2:0] pin_rise;

  // Rate model terms
  reg         reference_mux;
  wire [31:0] p_eff;
  wire [31:0] r_eff;
  wire [13:0] d_val;
  wire [31:0] k_scaled;
  wire [31:0] pll_inc;
  wire [31:0] p_scaled;
  wire [31:0] core_div_eff;
  wire [31:0] core_limit;
  wire [31:0] sample_limit;

  // Outgoing clock counters
  reg  [6:0] bit_cnt;
  reg  [7:0] frame_cnt;
  wire [6:0] next_bit_cnt;
  wire [7:0] next_frame_cnt;
  wire [8:0] frame_half;
  wire       bit_wrap;
  wire       bit_rise;
  wire       clocks_idle;

  // Read path and control port strobes
  reg  [7:0] next_rdata;
  wire       reg_wr_en;
  wire       reg_rd_en;

  // Status outputs mirror the register fields
  assign pll_on_bit     = pll_on;
  assign pll_ref_source = ref_sel;
  // Port strobes gate on ce, so a frozen block takes no request
  assign reg_wr_en      = ce && reg_write;
  assign reg_rd_en      = ce && reg_read;

  // Register writes; enable comes up set so the PLL runs from reset
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pll_on           <= `APC_RST_PLL_ON;
      ref_sel          <= `APC_RST_REF_SEL;
      p_code           <= `APC_RST_P;
      j_val            <= `APC_RST_J;
      d_raw            <= `APC_RST_D;
      r_code           <= `APC_RST_R;
      core_clk_div     <= `APC_RST_DIV7;
      bitclk_out_div   <= `APC_RST_DIV7;
      frameclk_out_div <= `APC_RST_DIV8;
    end else if (reg_wr_en) begin
      // New coefficients act at once; software holds the clocks meanwhile
      case (reg_addr)
        `APC_ADDR_PLL_CTRL:  pll_on <= reg_wdata[`APC_PLL_ON_POS];
        `APC_ADDR_REF_SEL:   ref_sel <= reg_wdata[`APC_REF_SEL_HI:`APC_REF_SEL_LO];
        `APC_ADDR_PLL_P:     p_code <= reg_wdata[`APC_PQR_HI:0];
        `APC_ADDR_PLL_J:     j_val <= reg_wdata[`APC_J_HI:0];
        `APC_ADDR_PLL_D_HI:  d_raw[13:8] <= reg_wdata[`APC_D_HI_HI:0];
        `APC_ADDR_PLL_D_LO:  d_raw[7:0] <= reg_wdata;
        `APC_ADDR_PLL_R:     r_code <= reg_wdata[`APC_PQR_HI:0];
        `APC_ADDR_CORE_DIV:  core_clk_div <= reg_wdata[`APC_DIV7_HI:0];
        `APC_ADDR_BIT_DIV:   bitclk_out_div <= reg_wdata[`APC_DIV7_HI:0];
        `APC_ADDR_FRAME_DIV: frameclk_out_div <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Readback mux; unmapped offsets and reserved bits read zero, so
  // software may compare whole bytes without masking
  always @* begin
    case (reg_addr)
      `APC_ADDR_PLL_CTRL:  next_rdata = {7'h00, pll_on};
      `APC_ADDR_REF_SEL:   next_rdata = {1'b0, ref_sel, 4'h0};
      `APC_ADDR_PLL_P:     next_rdata = {4'h0, p_code};
      `APC_ADDR_PLL_J:     next_rdata = {2'h0, j_val};
      `APC_ADDR_PLL_D_HI:  next_rdata = {2'h0, d_raw[13:8]};
      `APC_ADDR_PLL_D_LO:  next_rdata = d_raw[7:0];
      `APC_ADDR_PLL_R:     next_rdata = {4'h0, r_code};
      `APC_ADDR_CORE_DIV:  next_rdata = {1'b0, core_clk_div};
      `APC_ADDR_BIT_DIV:   next_rdata = {1'b0, bitclk_out_div};
      `APC_ADDR_FRAME_DIV: next_rdata = frameclk_out_div;
      default:             next_rdata = `APC_RDATA_NONE;
    endcase
  end

  // Read data is registered and holds until the next read
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      reg_rdata       <= `APC_RDATA_NONE;
      reg_rdata_valid <= 1'b0;
    end else if (ce) begin
      reg_rdata_valid <= reg_read;
      if (reg_rd_en) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // Two flops per pin before any logic; a third flop feeds the edge detect
  // Limitation: pins above about half of ref_clk alias in this model
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_pin
      always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          pin_meta[gi] <= 1'b0;
          pin_sync[gi] <= 1'b0;
          pin_last[gi] <= 1'b0;
        end else if (ce) begin
          pin_meta[gi] <= pin_raw[gi];
          pin_sync[gi] <= pin_meta[gi];
          pin_last[gi] <= pin_sync[gi];
        end
      end
      assign pin_rise[gi] = pin_sync[gi] & ~pin_last[gi];
    end
  endgenerate

  // Reference select; with the PLL off only the master clock can drive
  // Unused select codes fall back to the master clock rather than stall
  always @* begin
    if (!pll_on) begin
      reference_mux = pin_rise[0];
    end else begin
      case (ref_sel)
        `APC_REF_MASTER: reference_mux = pin_rise[0];
        `APC_REF_BITCLK: reference_mux = pin_rise[1];
        `APC_REF_GPIO:   reference_mux = pin_rise[2];
        default:         reference_mux = pin_rise[0];
      endcase
    end
  end

  // Fraction clamps at four digits so K never reaches the next integer
  assign d_val = (d_raw > `APC_D_MAX) ? `APC_D_MAX : d_raw;
  // Codes hold value minus one: P 1..16, R 1..16
  assign p_eff = pll_on ? ({28'h0, p_code} + `APC_ONE32) : `APC_ONE32;
  assign r_eff = {28'h0, r_code} + `APC_ONE32;
  assign k_scaled = ({26'h0, j_val} * `APC_FRAC_ONE) + {18'h0, d_val};
  // PLL off passes the master clock straight through at unity ratio
  assign pll_inc = pll_on ? (k_scaled * r_eff) : `APC_FRAC_ONE;
  // Dividing by P scales the limits up instead of the increment down, so
  // no fraction of a reference edge is ever lost to rounding
  assign p_scaled     = p_eff * `APC_FRAC_ONE;
  assign core_div_eff = {25'h0, core_clk_div} + `APC_ONE32;
  assign core_limit   = p_scaled * core_div_eff;
  assign sample_limit = p_scaled * `APC_FS_RATIO;

  // Core clock: PLL output divided by the core divider
  // Both rate units see the same edges, so core and sample ticks stay locked
  apc_rate_unit u_core_rate (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .ce       (ce),
    .clear    (hold_clocks),
    .ref_edge (reference_mux),
    .inc      (pll_inc),
    .limit    (core_limit),
    .tick     (core_clk_tick)
  );

  // Sample rate: PLL output over the fixed frame ratio
  apc_rate_unit u_sample_rate (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .ce       (ce),
    .clear    (hold_clocks),
    .ref_edge (reference_mux),
    .inc      (pll_inc),
    .limit    (sample_limit),
    .tick     (sample_tick)
  );

  // Pins are driven only in clock-master mode
  // In slave mode the host owns both pins and the outputs idle low
  assign serial_bit_clock_oe = master_mode;
  assign frame_sync_clock_oe = master_mode;

  // Wrap on the master edge that ends a half period of the bit clock
  assign bit_wrap       = pin_rise[0] && (bit_cnt == bitclk_out_div);
  // A wrap while low is a rising bit clock edge, which steps the frame
  assign bit_rise       = bit_wrap && !serial_bit_clock_out;
  assign clocks_idle    = hold_clocks || !master_mode;
  assign next_bit_cnt   = bit_wrap ? 7'h00 : (bit_cnt + 7'h01);
  assign next_frame_cnt = (frame_cnt == frameclk_out_div) ? 8'h00 : (frame_cnt + 8'h01);
  assign frame_half     = ({1'b0, frameclk_out_div} + 9'h001) >> 1;

  // Outgoing bit clock toggles every (div+1) master edges. Holding it
  // restarts it low, so the first wrap after release is always a rise.
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bit_cnt              <= 7'h00;
      serial_bit_clock_out <= 1'b0;
    end else if (ce) begin
      if (clocks_idle) begin
        bit_cnt              <= 7'h00;
        serial_bit_clock_out <= 1'b0;
      end else if (pin_rise[0]) begin
        bit_cnt <= next_bit_cnt;
        if (bit_wrap) begin
          serial_bit_clock_out <= ~serial_bit_clock_out;
        end
      end
    end
  end

  // Frame clock counts whole bit clock periods; a zero divider only halves
  // the bit rate, as there is no room left for a duty split
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      frame_cnt            <= 8'h00;
      frame_sync_clock_out <= 1'b0;
    end else if (ce) begin
      if (clocks_idle) begin
        frame_cnt            <= 8'h00;
        frame_sync_clock_out <= 1'b0;
      end else if (bit_rise) begin
        frame_cnt <= next_frame_cnt;
        if (frameclk_out_div == 8'h00) begin
          frame_sync_clock_out <= ~frame_sync_clock_out;
        end else begin
          frame_sync_clock_out <= ({1'b0, next_frame_cnt} < frame_half);
        end
      end
    end
  end

endmodule // apc_clock_gen

// *** core/apc_consts.vh ***
/*
  Constants for the audio PLL clock generator: register offsets, field
  positions, reset values, reference codes and rate-model scale factors.
  Assumes it is included by its bare name from the design files under core/.
*/
`ifndef APC_CONSTS_VH
`define APC_CONSTS_VH

// Register offsets on the control port
`define APC_ADDR_PLL_CTRL   8'h04
`define APC_ADDR_REF_SEL    8'h0d
`define APC_ADDR_PLL_P      8'h14
`define APC_ADDR_PLL_J      8'h15
`define APC_ADDR_PLL_D_HI   8'h16
`define APC_ADDR_PLL_D_LO   8'h17
`define APC_ADDR_PLL_R      8'h18
`define APC_ADDR_CORE_DIV   8'h1b
`define APC_ADDR_BIT_DIV    8'h20
`define APC_ADDR_FRAME_DIV  8'h21

// Field positions
`define APC_PLL_ON_POS      0
`define APC_REF_SEL_HI      6
`define APC_REF_SEL_LO      4
`define APC_DIV7_HI         6
`define APC_PQR_HI          3
`define APC_J_HI            5
`define APC_D_HI_HI         5

// Reset values
`define APC_RST_PLL_ON      1'h1
`define APC_RST_REF_SEL     3'h0
`define APC_RST_P           4'h0
`define APC_RST_J           6'h08
`define APC_RST_D           14'h0000
`define APC_RST_R           4'h0
`define APC_RST_DIV7        7'h00
`define APC_RST_DIV8        8'h00
`define APC_RDATA_NONE      8'h00

// Reference source codes
`define APC_REF_MASTER      3'h0
`define APC_REF_BITCLK      3'h1
`define APC_REF_GPIO        3'h3

// Rate model: four decimal digits of fraction, sample rate divisor
`define APC_FRAC_ONE        32'd10000
`define APC_D_MAX           14'd9999
`define APC_FS_RATIO        32'd2048
`define APC_ONE32           32'd1

`endif

// *** core/apc_rate_unit.v ***
/*
  Fractional rate unit: emits one-cycle ticks at inc/limit times the rate of
  the reference edges, carrying the remainder so fractions do not drift.
  Assumes ref_edge is a one-cycle pulse in the ref_clk domain and that the
  average tick rate stays below one per ref_clk cycle.
*/
`timescale 1ns/1ns
module apc_rate_unit (
  // Clock and reset
  input  wire        ref_clk,
  input  wire        rst,
  input  wire        ce,
  // Control
  input  wire        clear,
  input  wire        ref_edge,
  input  wire [31:0] inc,
  input  wire [31:0] limit,
  // Output
  output reg         tick
);

  reg  [31:0] acc;
  wire [31:0] sum = acc + (ref_edge ? inc : 32'h0000_0000);

  // Backlog above the limit drains at one tick per cycle
  always @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      acc  <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (ce) begin
      if (clear) begin
        acc  <= 32'h0000_0000;
        tick <= 1'b0;
      end else if (sum >= limit) begin
        acc  <= sum - limit;
        tick <= 1'b1;
      end else begin
        acc  <= sum;
        tick <= 1'b0;
      end
    end
  end

endmodule // apc_rate_unit
